// [hdl/adc_port_device.sv]
// Converter end of the byte-wide port: strobe decode, conversion sequencing and readout.
`timescale 1ns/1ns
module adc_port_device (
  // Clock and reset
  input  wire logic                           hclk,
  input  wire logic                           hresetn,
  // Pins toward the host
  adc_port_if.device                          pins,
  // Converter side
  input  wire logic [adc_port_pkg::RES_W-1:0] sample_in,
  input  wire logic                           ext_clk_mode,
  output logic      [adc_port_pkg::BUS_W-1:0] config_out,
  output logic                                tracking
);
  typedef enum logic [2:0] {
    S_IDLE,
    S_ACQ_INT,
    S_ACQ_EXT,
    S_CONV,
    S_DONE
  } conv_state_e;

  typedef struct packed {
    conv_state_e                   st;
    logic                          prev_wr;
    logic                          prev_rd;
    logic                          prev_clk;
    logic [7:0]                    div;
    logic [3:0]                    edges;
    logic [adc_port_pkg::BUS_W-1:0] cfg;
    logic [adc_port_pkg::RES_W-1:0] sample;
    logic [adc_port_pkg::RES_W-1:0] result;
    logic                          done_n;
    logic                          reading;
    logic [adc_port_pkg::BUS_W-1:0] dout;
    logic                          track;
  } dev_state_s;

  dev_state_s q_ff;
  dev_state_s nxt_q;

  logic [12:0] pin_f;
  logic        f_cs_n;
  logic        f_rd_n;
  logic        f_wr_n;
  logic        f_upper;
  logic        f_clk;
  logic [7:0]  f_data;
  logic        wr_rise;
  logic        rd_fall;
  logic        int_tick;
  logic        clk_fall;

  // Every host pin is asynchronous here, so all of them pass the filter.
  // Filters start at each pin's idle level (byte select and clock low), so reset makes no edge.
  pin_sync #(
    .WIDTH   (13),
    .RST_VAL (13'h1CFF)
  ) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in ({pins.cs_n, pins.rd_n, pins.wr_n, pins.upper_byte_select,
                pins.clk_pin, pins.data_bus}),
    .sync_out (pin_f)
  );

  // Unpack the filtered pins.
  assign f_cs_n  = pin_f[12];
  assign f_rd_n  = pin_f[11];
  assign f_wr_n  = pin_f[10];
  assign f_upper = pin_f[9];
  assign f_clk   = pin_f[8];
  assign f_data  = pin_f[7:0];

  // Strobe edges only count while the chip is selected.
  assign wr_rise  = !f_cs_n && !q_ff.prev_wr && f_wr_n;
  assign rd_fall  = !f_cs_n && q_ff.prev_rd && !f_rd_n;
  assign int_tick = (q_ff.div == 8'h00);

  // The converter steps on falling edges of the pin clock or of its own divider.
  assign clk_fall = ext_clk_mode ? (q_ff.prev_clk && !f_clk) : int_tick;

  // Last count of the free-running divider that paces the converter's own clock.
  localparam logic [7:0] INT_CLK_CYC_M1 = adc_port_pkg::INT_CLK_CYC - 8'h01;

  // Edge counter step, shared by acquisition and conversion.
  function automatic logic [3:0] edge_step(input logic [3:0] cnt);
    return cnt + 4'h1;
  endfunction : edge_step

  // True on the edge that completes a phase of the given length.
  function automatic logic edge_last(input logic [3:0] cnt, input logic [3:0] total);
    return cnt == total - 4'h1;
  endfunction : edge_last

  // Next state; the divider runs free, so the first internal tick lands anywhere in a period.
  always_comb begin
    nxt_q          = q_ff;
    nxt_q.prev_wr  = f_wr_n;
    nxt_q.prev_rd  = f_rd_n;
    nxt_q.prev_clk = f_clk;
    nxt_q.div      = (q_ff.div == INT_CLK_CYC_M1) ? 8'h00 : q_ff.div + 8'h01;

    // A read that overlaps a conversion returns the previous result.
    // start read drive
    if (rd_fall) begin
      nxt_q.reading = 1'b1;
      nxt_q.done_n  = 1'b1;
    end
    if (f_cs_n || f_rd_n) begin
      nxt_q.reading = 1'b0;
    end

    case (q_ff.st)
      S_IDLE, S_DONE: begin
        if (wr_rise) begin
          nxt_q.cfg    = f_data;
          nxt_q.track  = 1'b1;
          nxt_q.edges  = 4'h0;
          nxt_q.done_n = 1'b1;
          nxt_q.st     = f_data[adc_port_pkg::CFG_ACQ_BIT] ? S_ACQ_EXT : S_ACQ_INT;
        end
      end
      S_ACQ_INT: begin
        if (clk_fall) begin
          nxt_q.edges = edge_step(q_ff.edges);
          if (edge_last(q_ff.edges, adc_port_pkg::ACQ_EDGES)) begin
            nxt_q.sample = sample_in;
            nxt_q.track  = 1'b0;
            nxt_q.edges  = 4'h0;
            nxt_q.st     = S_CONV;
          end
        end
      end
      S_ACQ_EXT: begin
        if (wr_rise) begin
          nxt_q.sample = sample_in;
          nxt_q.track  = 1'b0;
          nxt_q.edges  = 4'h0;
          nxt_q.st     = S_CONV;
        end
      end
      S_CONV: begin
        // Write strobes during conversion are ignored; the host must not send them.
        if (clk_fall) begin
          nxt_q.edges = edge_step(q_ff.edges);
          if (edge_last(q_ff.edges, adc_port_pkg::CONV_EDGES)) begin
            // No approximation is modelled: the result is the held sample as it stands.
            nxt_q.result = q_ff.sample;
            nxt_q.done_n = 1'b0;
            nxt_q.st     = S_DONE;
          end
        end
      end
      default: begin
        nxt_q.st = S_IDLE;
      end
    endcase

    // Data follow the byte select a cycle late while driving.
    // low eight bits
    nxt_q.dout = q_ff.result[7:0];
    if (f_upper) begin
      nxt_q.dout                               = 8'h00;
      nxt_q.dout[adc_port_pkg::DATA_LANE_ONE]  = q_ff.result[9];
      nxt_q.dout[adc_port_pkg::DATA_LANE_ZERO] = q_ff.result[8];
    end
  end

  // State register; each edge memory starts at its pin's idle level.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_ff <= '{st: S_IDLE, prev_wr: 1'b1, prev_rd: 1'b1, prev_clk: 1'b0,
                div: 8'h00, edges: 4'h0, cfg: 8'h00, sample: 10'h000,
                result: 10'h000, done_n: 1'b1, reading: 1'b0, dout: 8'h00,
                track: 1'b0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Outputs come straight from the state register.
  assign pins.done_n   = q_ff.done_n;
  assign pins.d_dev    = q_ff.dout;
  assign pins.d_dev_oe = q_ff.reading;
  assign config_out    = q_ff.cfg;
  assign tracking      = q_ff.track;
endmodule : adc_port_device

// [hdl/adc_port_host.sv]
// Host end: AHB-Lite register slave that sequences the converter's strobes.
//
// The AHB-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
module adc_port_host (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Interrupt
  output logic             irq,
  // Pins toward the converter
  adc_port_if.host         pins
);
  typedef enum logic [2:0] {
    H_IDLE,
    H_WR_LO,
    H_WR_HI,
    H_RD_LO,
    H_RD_HI
  } host_state_e;

  typedef struct packed {
    host_state_e hst;
    logic [7:0]  cnt;
    logic        wr_pend;
    logic [7:0]  waddr;
    logic [7:0]  cfg;
    logic        ext_clk;
    logic        acq_lock;
    logic [9:0]  result;
    logic [1:0]  irq_st;
    logic [1:0]  irq_mask;
    logic        prev_done;
    logic [7:0]  clkdiv;
    logic        clk_pin;
    logic        cs_n;
    logic        rd_n;
    logic        wr_n;
    logic        upper_sel;
    logic        d_oe;
    logic [7:0]  d_out;
    logic [31:0] rdata;
    logic        irq;
  } host_state_s;

  host_state_s q_ff;
  host_state_s nxt_q;
  logic [8:0]  pin_f;
  logic        addr_ok;
  logic [1:0]  irq_set;
  logic [1:0]  irq_clr;
  logic        idle;
  logic        done_fall;

  // Last count of each strobe phase and of each half period of the pin clock.
  localparam logic [7:0] WR_M1       = adc_port_pkg::WR_PULSE_CYC - 8'h01;
  localparam logic [7:0] RD_M1       = adc_port_pkg::RD_WAIT_CYC - 8'h01;
  localparam logic [7:0] EXT_HALF_M1 = adc_port_pkg::EXT_HALF_CYC - 8'h01;

  // The converter's outputs are asynchronous to this clock.
  pin_sync #(
    .WIDTH   (9),
    .RST_VAL (9'h1FF)
  ) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in ({pins.done_n, pins.data_bus}),
    .sync_out (pin_f)
  );

  // Only whole-word transfers are decoded; the slave never waits.
  assign addr_ok   = hsel && hready && htrans[1] && (hsize == 3'h2);
  assign idle      = (q_ff.hst == H_IDLE);
  assign done_fall = q_ff.prev_done && !pin_f[8];

  always_comb begin
    nxt_q           = q_ff;
    irq_set         = 2'h0;
    irq_clr         = 2'h0;
    nxt_q.prev_done = pin_f[8];
    nxt_q.wr_pend   = 1'b0;

    // A finished conversion lifts the lock that keeps write strobes off the pins.
    if (done_fall) begin
      irq_set[adc_port_pkg::IRQ_DONE] = 1'b1;
      nxt_q.acq_lock                  = 1'b0;
    end

    if (q_ff.ext_clk) begin
      nxt_q.clkdiv = (q_ff.clkdiv == EXT_HALF_M1) ? 8'h00 : q_ff.clkdiv + 8'h01;
      if (q_ff.clkdiv == EXT_HALF_M1) begin
        nxt_q.clk_pin = !q_ff.clk_pin;
      end
    end else begin
      nxt_q.clkdiv  = 8'h00;
      nxt_q.clk_pin = 1'b0;
    end

    // Pin sequencer; the counter paces each strobe phase.
    nxt_q.cnt = q_ff.cnt + 8'h01;
    case (q_ff.hst)
      H_IDLE: begin
        nxt_q.cnt = 8'h00;
      end
      H_WR_LO: begin
        if (q_ff.cnt == WR_M1) begin
          nxt_q.wr_n = 1'b1;
          nxt_q.cnt  = 8'h00;
          nxt_q.hst  = H_WR_HI;
        end
      end
      H_WR_HI: begin
        // Data and select stay on past the rise to cover the far-end filter.
        if (q_ff.cnt == WR_M1) begin
          nxt_q.cs_n = 1'b1;
          nxt_q.d_oe = 1'b0;
          nxt_q.hst  = H_IDLE;
        end
      end
      H_RD_LO: begin
        if (q_ff.cnt == RD_M1) begin
          nxt_q.result[7:0] = pin_f[7:0];
          nxt_q.upper_sel   = 1'b1;
          nxt_q.cnt         = 8'h00;
          nxt_q.hst         = H_RD_HI;
        end
      end
      H_RD_HI: begin
        if (q_ff.cnt == RD_M1) begin
          nxt_q.result[9:8] = pin_f[adc_port_pkg::DATA_LANE_ONE:adc_port_pkg::DATA_LANE_ZERO];
          nxt_q.rd_n        = 1'b1;
          nxt_q.cs_n        = 1'b1;
          nxt_q.upper_sel   = 1'b0;
          nxt_q.hst         = H_IDLE;
          irq_set[adc_port_pkg::IRQ_READ] = 1'b1;
        end
      end
      default: begin
        nxt_q.hst = H_IDLE;
      end
    endcase

    // Data phase of a write; a strobe is dropped while busy, a read only while the pins are busy.
    if (q_ff.wr_pend) begin
      case (q_ff.waddr)
        adc_port_pkg::OFS_CONFIG: begin
          nxt_q.cfg = hwdata[7:0];
          if (idle && !q_ff.acq_lock) begin
            nxt_q.d_out = hwdata[7:0];
            nxt_q.d_oe  = 1'b1;
            nxt_q.cs_n  = 1'b0;
            nxt_q.wr_n  = 1'b0;
            nxt_q.hst   = H_WR_LO;
            nxt_q.acq_lock = !hwdata[adc_port_pkg::CFG_ACQ_BIT];
          end
        end
        adc_port_pkg::OFS_CTRL: begin
          nxt_q.ext_clk = hwdata[adc_port_pkg::CTRL_EXT_CLK];
        end
        adc_port_pkg::OFS_CMD: begin
          if (idle && !q_ff.acq_lock && hwdata[adc_port_pkg::CMD_STROBE]) begin
            nxt_q.d_out = q_ff.cfg;
            nxt_q.d_oe  = 1'b1;
            nxt_q.cs_n  = 1'b0;
            nxt_q.wr_n  = 1'b0;
            nxt_q.hst   = H_WR_LO;
          end else if (idle && hwdata[adc_port_pkg::CMD_READ]) begin
            nxt_q.cs_n      = 1'b0;
            nxt_q.rd_n      = 1'b0;
            nxt_q.upper_sel = 1'b0;
            nxt_q.hst       = H_RD_LO;
          end
        end
        adc_port_pkg::OFS_IRQ_MASK: begin
          nxt_q.irq_mask = hwdata[1:0];
        end
        default: begin
        end
      endcase
    end

    // Address phase; read data is registered here for the data phase.
    nxt_q.rdata = 32'h0000_0000;
    if (addr_ok && hwrite) begin
      nxt_q.wr_pend = 1'b1;
      nxt_q.waddr   = haddr[7:0];
    end else if (addr_ok) begin
      case (haddr[7:0])
        adc_port_pkg::OFS_CONFIG:   nxt_q.rdata[7:0] = q_ff.cfg;
        adc_port_pkg::OFS_CTRL:     nxt_q.rdata[adc_port_pkg::CTRL_EXT_CLK] = q_ff.ext_clk;
        adc_port_pkg::OFS_RESULT: begin
          nxt_q.rdata[9:0] = q_ff.result;
          nxt_q.rdata[adc_port_pkg::RESULT_BUSY] = !idle || q_ff.acq_lock;
        end
        adc_port_pkg::OFS_IRQ_STAT: begin
          nxt_q.rdata[1:0] = q_ff.irq_st;
          irq_clr          = 2'h3;
        end
        adc_port_pkg::OFS_IRQ_MASK: nxt_q.rdata[1:0] = q_ff.irq_mask;
        default:                    nxt_q.rdata = 32'h0000_0000;
      endcase
    end

    // A new event beats a clearing read in the same cycle.
    nxt_q.irq_st = (q_ff.irq_st & ~irq_clr) | irq_set;
    nxt_q.irq    = |(q_ff.irq_st & q_ff.irq_mask);
  end

  // State register; strobes and select rest high.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_ff <= '{hst: H_IDLE, cnt: 8'h00, wr_pend: 1'b0, waddr: 8'h00,
                cfg: adc_port_pkg::CONFIG_RST, ext_clk: 1'b0, acq_lock: 1'b0,
                result: 10'h000, irq_st: 2'h0, irq_mask: adc_port_pkg::MASK_RST,
                prev_done: 1'b1, clkdiv: 8'h00, clk_pin: 1'b0, cs_n: 1'b1,
                rd_n: 1'b1, wr_n: 1'b1, upper_sel: 1'b0, d_oe: 1'b0, d_out: 8'h00,
                rdata: 32'h0000_0000, irq: 1'b0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Outputs straight from the state register; ready and response are constant.
  assign hrdata                 = q_ff.rdata;
  assign hreadyout              = 1'b1;
  assign hresp                  = 1'b0;
  assign irq                    = q_ff.irq;
  assign pins.cs_n              = q_ff.cs_n;
  assign pins.rd_n              = q_ff.rd_n;
  assign pins.wr_n              = q_ff.wr_n;
  assign pins.upper_byte_select = q_ff.upper_sel;
  assign pins.clk_pin           = q_ff.clk_pin;
  assign pins.d_host            = q_ff.d_out;
  assign pins.d_host_oe         = q_ff.d_oe;
endmodule : adc_port_host

// [hdl/pin_sync.sv]
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ns
module pin_sync #(
  parameter int              WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Raw pins and filtered result
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] filt;
  } sync_state_s;

  sync_state_s q_ff;
  sync_state_s nxt_q;

  // Stage one only feeds stage two; the filter looks at stages two and three.
  always_comb begin
    nxt_q      = q_ff;
    nxt_q.s1   = async_in;
    nxt_q.s2   = q_ff.s1;
    nxt_q.s3   = q_ff.s2;
    nxt_q.filt = (q_ff.s2 & ~(q_ff.s2 ^ q_ff.s3)) | (q_ff.filt & (q_ff.s2 ^ q_ff.s3));
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_ff <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign sync_out = q_ff.filt;
endmodule : pin_sync

// [shared/adc_port_if.sv]
// Pin bundle between the converter port and its host controller.
`timescale 1ns/1ns
interface adc_port_if;
  logic       cs_n;
  logic       rd_n;
  logic       wr_n;
  logic       upper_byte_select;
  logic       clk_pin;
  logic       done_n;
  logic [7:0] d_host;
  logic       d_host_oe;
  logic [7:0] d_dev;
  logic       d_dev_oe;
  logic [7:0] data_bus;

  // Wire level of the shared bus; an undriven bus floats high as if pulled up.
  assign data_bus = d_dev_oe ? d_dev : (d_host_oe ? d_host : 8'hFF);

  modport device (
    input  cs_n, rd_n, wr_n, upper_byte_select, clk_pin, data_bus,
    output done_n, d_dev, d_dev_oe
  );
  modport host (
    output cs_n, rd_n, wr_n, upper_byte_select, clk_pin, d_host, d_host_oe,
    input  done_n, data_bus
  );
endinterface : adc_port_if

// [shared/adc_port_pkg.sv]
// Shared constants for the byte-wide converter port and its host controller.
package adc_port_pkg;
  // Widths of the result and of the parallel bus.
  localparam int RES_W = 10;
  localparam int BUS_W = 8;
  // Lanes that carry the top two result bits when the upper byte is selected.
  localparam int DATA_LANE_ONE  = 1;
  localparam int DATA_LANE_ZERO = 0;
  // Configuration bit that selects external acquisition when set.
  localparam int CFG_ACQ_BIT = 5;

  // System clock rate.
  localparam int CLK_MHZ = 50;
  // Host strobe width, and the time it waits for read data to settle.
  localparam int WR_PULSE_NS = 120;
  localparam int RD_WAIT_NS  = 240;
  // Half period of the clock the host supplies in external clock mode.
  localparam int EXT_CLK_HALF_NS = 104;
  // Period of the converter's own clock in internal clock mode.
  localparam int INT_CLK_NS = 250;
  // Cycle counts derived from the times above.
  localparam logic [7:0] WR_PULSE_CYC  = 8'((WR_PULSE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] RD_WAIT_CYC   = 8'((RD_WAIT_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] EXT_HALF_CYC  = 8'((EXT_CLK_HALF_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] INT_CLK_CYC   = 8'((INT_CLK_NS * CLK_MHZ) / 1000);
  // Falling clock edges to the hold point, and edges per conversion.
  localparam logic [3:0] ACQ_EDGES  = 4'h4;
  localparam logic [3:0] CONV_EDGES = 4'hA;

  // Host controller register byte offsets.
  localparam logic [7:0] OFS_CONFIG   = 8'h00;
  localparam logic [7:0] OFS_CTRL     = 8'h04;
  localparam logic [7:0] OFS_CMD      = 8'h08;
  localparam logic [7:0] OFS_RESULT   = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  // Field positions inside those registers.
  localparam int CTRL_EXT_CLK = 0;
  localparam int CMD_STROBE   = 0;
  localparam int CMD_READ     = 1;
  localparam int RESULT_BUSY  = 16;
  localparam int IRQ_DONE     = 0;
  localparam int IRQ_READ     = 1;
  // Reset values.
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [1:0] MASK_RST   = 2'h0;
endpackage : adc_port_pkg

// [test/adc_port_sva.sv]
// Concurrent checks on the pins between the converter port and its host controller.
`timescale 1ns/1ns
module adc_port_sva (
  // Clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // Strobes and status
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic       upper_byte_select,
  input wire logic       done_n,
  // Data lanes
  input wire logic       d_host_oe,
  input wire logic       d_dev_oe,
  input wire logic [7:0] d_dev,
  input wire logic [7:0] data_bus
);
  logic [3:0] quiet_ff;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Cycles since a strobe was last low; done may only rise soon after one.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      quiet_ff <= 4'h0;
    end else if (!rd_n || !wr_n) begin
      quiet_ff <= 4'h0;
    end else if (quiet_ff != 4'hF) begin
      quiet_ff <= quiet_ff + 4'h1;
    end
  end

  // Bus ownership; the filter delay allows a few cycles of release latency.
  chk_cs_release: assert property (cs_n [*8] |-> !d_dev_oe)
    else $error("Device drives bus while deselected.");
  chk_rd_release: assert property (rd_n [*8] |-> !d_dev_oe)
    else $error("Device drives bus after read ended.");
  chk_no_clash: assert property (!(d_dev_oe && d_host_oe))
    else $error("Both ends drive the bus.");
  chk_read_drive: assert property ($fell(rd_n) && !cs_n |-> ##[1:8] d_dev_oe)
    else $error("Read strobe did not enable data.");
  chk_upper_lanes: assert property ((d_dev_oe && upper_byte_select) [*8] |-> d_dev[7:2] == 6'h00)
    else $error("Upper byte has bits above lane one.");
  // Completion line behaviour.
  chk_done_fall: assert property ($rose(wr_n) && !cs_n && !data_bus[5] |-> ##[8:400] !done_n)
    else $error("Conversion did not complete in time.");
  chk_done_clear: assert property ($fell(rd_n) && !cs_n && !done_n |-> ##[1:8] done_n)
    else $error("Read strobe did not clear done.");
  chk_done_cause: assert property ($rose(done_n) |-> quiet_ff < 4'hC)
    else $error("Done rose without a strobe.");
  // Host strobes stay under chip select.
  chk_wr_under_cs: assert property (!wr_n || $rose(wr_n) |-> !cs_n)
    else $error("Write strobe outside chip select.");
  chk_rd_under_cs: assert property (!rd_n |-> !cs_n)
    else $error("Read strobe outside chip select.");

  // Main scenarios reached.
  cov_done: cover property ($fell(done_n));
  cov_upper: cover property (d_dev_oe && upper_byte_select);
  cov_ext_acq: cover property ($rose(wr_n) && !cs_n && data_bus[5]);
endmodule : adc_port_sva

// [test/tb_top.sv]
// Self-checking bench: AHB-Lite host controller joined to the converter port.
`timescale 1ns/1ns
module tb_top;
  // Bus, clock and converter side
  logic        hclk;
  logic        hresetn;
  logic        hwrite;
  logic        dp;
  logic        ext_clk_mode;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic        tracking;
  logic        clk_was;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [9:0]  sample;
  logic [7:0]  cfg;
  logic [7:0]  config_out;
  logic [31:0] expq[$];
  logic [31:0] mskq[$];
  int          n_fail;
  int          checked;
  int          cnt;

  adc_port_if i_adc_port_if ();

  adc_port_device i_adc_port_device (.hclk(hclk), .hresetn(hresetn),
    .pins(i_adc_port_if.device), .sample_in(sample), .ext_clk_mode(ext_clk_mode),
    .config_out(config_out), .tracking(tracking));

  adc_port_host i_adc_port_host (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .pins(i_adc_port_if.host));

  adc_port_sva i_adc_port_sva (.hclk(hclk), .hresetn(hresetn), .cs_n(i_adc_port_if.cs_n),
    .rd_n(i_adc_port_if.rd_n), .wr_n(i_adc_port_if.wr_n),
    .upper_byte_select(i_adc_port_if.upper_byte_select), .done_n(i_adc_port_if.done_n),
    .d_host_oe(i_adc_port_if.d_host_oe), .d_dev_oe(i_adc_port_if.d_dev_oe),
    .d_dev(i_adc_port_if.d_dev), .data_bus(i_adc_port_if.data_bus));

  // Counts a comparison and reports a difference at once.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // One single word transfer; a read leaves its expectation and mask in the queues.
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h00000000;
    dp     <= !w;
    if (!w) begin
      expq.push_back(d);
      mskq.push_back(m);
    end
    do @(posedge hclk); while (hreadyout !== 1'b1);
    dp <= 1'b0;
  endtask : ahb

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  // Free-running system clock.
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // Read data is taken at the edge that ends the data phase, before it is overwritten.
  always @(posedge hclk) begin
    if (dp && hreadyout && expq.size() > 0) begin
      check(hrdata & mskq.pop_front(), expq.pop_front());
    end
  end

  // A hang anywhere counts as a failure; the tests need well under a tenth of this.
  initial begin
    repeat (40000) @(posedge hclk);
    n_fail++;
    $display("MISMATCH at %0t: run did not finish", $time);
    wrap_up();
  end

  // Main sequence: reset values, then every clock and acquisition mode pairing.
  initial begin
    {hresetn, htrans, haddr, hwrite, hwdata, dp, ext_clk_mode, sample} = '0;
    hsize   = 3'h2;
    n_fail  = 0;
    checked = 0;
    void'($urandom(32'h8F50));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, adc_port_pkg::OFS_CONFIG, 32'h00000000, 32'h000000FF);
    ahb(1'b0, adc_port_pkg::OFS_IRQ_MASK, 32'h00000000, 32'h00000003);
    ahb(1'b0, 8'h18, 32'h00000000, 32'hFFFFFFFF);
    $display("Test reset values done");
    for (int m = 0; m < 4; m++) begin
      sample       <= 10'($urandom);
      ext_clk_mode <= m[0];
      cfg = 8'($urandom);
      cfg[adc_port_pkg::CFG_ACQ_BIT] = m[1];
      ahb(1'b1, adc_port_pkg::OFS_CTRL, 32'(m[0]), 32'h0);
      ahb(1'b1, adc_port_pkg::OFS_IRQ_MASK, (m == 2) ? 32'h0 : 32'h3, 32'h0);
      ahb(1'b1, adc_port_pkg::OFS_CONFIG, {24'h000000, cfg}, 32'h0);
      for (cnt = 0; cnt < 100 && tracking !== 1'b1; cnt++) @(posedge hclk);
      for (cnt = 0; cnt < 400 && tracking === 1'b1; cnt++) @(posedge hclk);
      if (m[1]) begin
        // Only the next write strobe may end an external acquisition.
        check(32'(tracking & i_adc_port_if.done_n), 32'h1);
        ahb(1'b1, adc_port_pkg::OFS_CMD, 32'h1, 32'h0);
        for (cnt = 0; cnt < 40 && tracking === 1'b1; cnt++) @(posedge hclk);
        check(32'(tracking), 32'h0);
      end else begin
        check(32'(cnt >= 34 && cnt <= 52), 32'h1);
      end
      check(32'(config_out), 32'(cfg));
      // The pin clock flips once per half period in external mode and stays low otherwise.
      clk_was = i_adc_port_if.clk_pin;
      repeat (adc_port_pkg::EXT_HALF_CYC) @(posedge hclk);
      check(32'(i_adc_port_if.clk_pin), m[0] ? 32'(!clk_was) : 32'h0);
      for (cnt = 0; cnt < 600 && i_adc_port_if.done_n !== 1'b0; cnt++) @(posedge hclk);
      repeat (8) @(posedge hclk);
      check(32'(irq), 32'(m != 2));
      ahb(1'b0, adc_port_pkg::OFS_IRQ_STAT, 32'h1, 32'h1);
      ahb(1'b0, adc_port_pkg::OFS_IRQ_STAT, 32'h0, 32'h3);
      ahb(1'b1, adc_port_pkg::OFS_CMD, 32'h2, 32'h0);
      for (cnt = 0; cnt < 20 && i_adc_port_if.rd_n !== 1'b0; cnt++) @(posedge hclk);
      repeat (10) @(posedge hclk);
      check(32'(i_adc_port_if.done_n), 32'h1);
      for (cnt = 0; cnt < 100 && i_adc_port_if.cs_n !== 1'b1; cnt++) @(posedge hclk);
      repeat (8) @(posedge hclk);
      check(32'(i_adc_port_if.data_bus), 32'h000000FF);
      ahb(1'b0, adc_port_pkg::OFS_RESULT, {22'h0, sample}, 32'h000103FF);
      ahb(1'b0, adc_port_pkg::OFS_IRQ_STAT, 32'h2, 32'h2);
      $display("Test mode %0d done", m);
    end
    repeat (4) @(posedge hclk);
    wrap_up();
  end
endmodule : tb_top
